/* rtl/dsc_decoder.v */
`timescale 1ns/1ps
`include "dsc_map.vh"
module dsc_decoder #(
    parameter [3:0] VERSION = 4'h6 // Arbitrary value.
) (
    input  wire        CLOCK,
    input  wire        RST,
    input  wire        CMD_VALID,
    input  wire        CMD_LONG,
    input  wire [15:0] CMD_WORD,
    input  wire [3:0]  CMD_CRC,
    input  wire [9:0]  AN0_DATA,
    input  wire [9:0]  AN1_DATA,
    input  wire [2:0]  IO_IN,
    input  wire        FUSE_PARITY_FLAG,
    output wire        RSP_VALID,
    output wire        RSP_LONG,
    output wire [15:0] RSP_WORD,
    output wire [3:0]  RSP_CRC,
    output wire [4:0]  RSP_BITS,
    output wire        CMD_CRC_ERR,
    output wire [2:0]  IO_OUT,
    output wire [2:0]  IO_OE,
    output wire        HS_SWITCH_CLOSE,
    output wire        LS_SWITCH_CLOSE,
    output wire        OSC_DITHER,
    output wire        FRAMING_ENHANCED,
    output wire [4:0]  SHORT_WORD_BITS
);
    reg  [3:0]  dev_addr_q;
    reg  [3:0]  dev_addr_d;
    reg         high_side_switch_ctl_q;
    reg         high_side_switch_ctl_d;
    reg         low_side_switch_ctl_q;
    reg         low_side_switch_ctl_d;
    reg         oscillator_dither_q;
    reg         oscillator_dither_d;
    reg  [2:0]  pin_direction_q;
    reg  [2:0]  pin_direction_d;
    reg  [2:0]  pin_level_q;
    reg  [2:0]  pin_level_d;
    reg  [3:0]  crc_poly_q;
    reg  [3:0]  crc_poly_d;
    reg  [3:0]  crc_seed_q;
    reg  [3:0]  crc_seed_d;
    reg  [3:0]  short_word_length_q;
    reg  [3:0]  short_word_length_d;
    reg  [3:0]  framing_select_q;
    reg  [3:0]  framing_select_d;
    reg         rsp_valid_q;
    reg         rsp_valid_d;
    reg         rsp_long_q;
    reg         rsp_long_d;
    reg  [15:0] rsp_word_q;
    reg  [15:0] rsp_word_d;
    reg  [3:0]  rsp_crc_q;
    reg  [4:0]  rsp_bits_q;
    reg  [4:0]  rsp_bits_d;
    reg         crc_err_q;
    reg         clear_d;
    reg  [3:0]  fmt_echo;

    wire        enhanced_long_word;
    wire        enhanced_short_word;
    wire [3:0]  act_poly;
    wire [3:0]  act_seed;
    wire [4:0]  sw_bits;
    wire [4:0]  cmd_bits;
    wire [3:0]  cmd_crc_calc;
    wire [3:0]  rsp_crc_calc;
    wire        crc_ok;
    wire        go;
    wire [3:0]  op;
    wire [3:0]  addr;
    wire        hit;
    wire        glob;
    wire        fmt_wr;
    wire [2:0]  fmt_ptr;
    wire [3:0]  fmt_val;

    // The programmed settings only take effect once format selection is all ones.
    assign enhanced_long_word  = (framing_select_q == `DSC_FSEL_ENH); // R3
    assign enhanced_short_word = enhanced_long_word &&
                                 (short_word_length_q == `DSC_SWLEN_ALT);
    assign act_poly = enhanced_long_word ? crc_poly_q : `DSC_POLY_RST;
    assign act_seed = enhanced_long_word ? crc_seed_q : `DSC_SEED_RST;
    assign sw_bits  = enhanced_short_word ? `DSC_LEN_SW10 : `DSC_LEN_SW8;
    assign cmd_bits = CMD_LONG ? `DSC_LEN_LONG : sw_bits;

    dsc_crc4 #(
        .W     (16)
    ) u_cmd_crc (
        .data  (CMD_WORD),
        .nbits (cmd_bits),
        .taps  (act_poly),
        .seed  (act_seed),
        .crc   (cmd_crc_calc)
    );

    // A corrupted command is dropped whole rather than half-applied.
    assign crc_ok  = (cmd_crc_calc == CMD_CRC); // R8
    assign go      = CMD_VALID && crc_ok;
    assign op      = CMD_WORD[`DSC_F_OP]; // R9
    assign addr    = CMD_WORD[`DSC_F_ADDR];
    assign hit     = (addr == dev_addr_q);
    assign glob    = (addr == `DSC_ADDR_GLOBAL);
    assign fmt_wr  = CMD_WORD[`DSC_B_RW];
    assign fmt_ptr = CMD_WORD[`DSC_F_PTR];
    assign fmt_val = CMD_WORD[`DSC_F_VAL];

    always @* begin
        dev_addr_d             = dev_addr_q;
        high_side_switch_ctl_d = high_side_switch_ctl_q;
        low_side_switch_ctl_d  = low_side_switch_ctl_q;
        oscillator_dither_d    = oscillator_dither_q;
        pin_direction_d        = pin_direction_q;
        pin_level_d            = pin_level_q;
        crc_poly_d             = crc_poly_q;
        crc_seed_d             = crc_seed_q;
        short_word_length_d    = short_word_length_q;
        framing_select_d       = framing_select_q;
        rsp_valid_d            = 1'b0;
        rsp_long_d             = rsp_long_q;
        rsp_word_d             = rsp_word_q;
        rsp_bits_d             = rsp_bits_q;
        clear_d                = 1'b0;
        fmt_echo               = `DSC_ZERO4;
        if (go && CMD_LONG) begin
            case (op)
                `DSC_OP_INIT: begin
                    if (hit) begin
                        dev_addr_d             = CMD_WORD[`DSC_F_NEWADDR]; // R10
                        high_side_switch_ctl_d = CMD_WORD[`DSC_B_HS]; // R11
                        low_side_switch_ctl_d  = CMD_WORD[`DSC_B_LS]; // R11
                        oscillator_dither_d    = CMD_WORD[`DSC_B_DITHER]; // R12
                        rsp_valid_d = 1'b1;
                        rsp_word_d  = {CMD_WORD[`DSC_F_NEWADDR], `DSC_ZERO4, `DSC_ZERO1,
                                       CMD_WORD[`DSC_B_HS], CMD_WORD[`DSC_B_LS],
                                       `DSC_ZERO1, CMD_WORD[`DSC_F_NEWADDR]}; // R15
                    end
                end
                `DSC_OP_STATUS: begin
                    if (hit && !glob) begin
                        rsp_valid_d = 1'b1;
                        rsp_word_d  = {dev_addr_q, `DSC_ZERO4, `DSC_ZERO1,
                                       high_side_switch_ctl_q, low_side_switch_ctl_q,
                                       `DSC_ZERO2, IO_IN}; // R16
                    end
                end
                `DSC_OP_AN0: begin
                    if (hit && !glob) begin
                        rsp_valid_d = 1'b1;
                        rsp_word_d  = {dev_addr_q, `DSC_ZERO4, AN0_DATA[9:2]}; // R15
                    end
                end
                `DSC_OP_AN1: begin
                    if (hit && !glob) begin
                        rsp_valid_d = 1'b1;
                        rsp_word_d  = {dev_addr_q, `DSC_ZERO4, AN1_DATA[9:2]}; // R15
                    end
                end
                `DSC_OP_IOCTL: begin
                    if (hit && !glob) begin
                        pin_direction_d = CMD_WORD[`DSC_F_DIR]; // R13
                        pin_level_d     = CMD_WORD[`DSC_F_LEVEL]; // R14
                        rsp_valid_d     = 1'b1;
                        rsp_word_d      = {dev_addr_q, `DSC_ZERO4, `DSC_ZERO1,
                                           CMD_WORD[`DSC_F_LEVEL], `DSC_ZERO1,
                                           CMD_WORD[`DSC_F_DIR]};
                    end
                end
                `DSC_OP_ID: begin
                    if (hit && !glob) begin
                        rsp_valid_d = 1'b1;
                        rsp_word_d  = {dev_addr_q, `DSC_ZERO4, VERSION,
                                       `DSC_ZERO3, FUSE_PARITY_FLAG};
                    end
                end
                `DSC_OP_CLEAR: begin
                    if (hit || glob)
                        clear_d = 1'b1;
                end
                `DSC_OP_FMT: begin
                    if (hit || glob) begin // R19
                        if (fmt_wr) begin // R18
                            case (fmt_ptr)
                                `DSC_LOC_POLY: begin
                                    if (!enhanced_long_word)
                                        crc_poly_d = fmt_val; // R7
                                end
                                `DSC_LOC_SEED: begin
                                    if (!enhanced_long_word)
                                        crc_seed_d = fmt_val; // R7
                                end
                                `DSC_LOC_SWLEN: begin
                                    if (!enhanced_long_word &&
                                        (fmt_val == `DSC_SWLEN_RST ||
                                         fmt_val == `DSC_SWLEN_ALT))
                                        short_word_length_d = fmt_val; // R2
                                end
                                `DSC_LOC_FSEL: begin
                                    if (framing_select_q == `DSC_FSEL_STD)
                                        framing_select_d = (fmt_val == `DSC_FSEL_ENH) ?
                                            `DSC_FSEL_ENH : `DSC_FSEL_STD; // R4
                                    else
                                        framing_select_d = (fmt_val == `DSC_FSEL_STD) ?
                                            `DSC_FSEL_STD : `DSC_FSEL_ENH; // R5 R6
                                end
                                default: begin
                                    crc_poly_d = crc_poly_q;
                                end
                            endcase
                        end
                        // The echo shows what the location holds after the command.
                        case (fmt_ptr)
                            `DSC_LOC_POLY:  fmt_echo = crc_poly_d;
                            `DSC_LOC_SEED:  fmt_echo = crc_seed_d;
                            `DSC_LOC_SWLEN: fmt_echo = short_word_length_d;
                            `DSC_LOC_FSEL:  fmt_echo = framing_select_d;
                            default:        fmt_echo = `DSC_ZERO4;
                        endcase
                        if (!glob) begin
                            rsp_valid_d = 1'b1;
                            rsp_word_d  = {dev_addr_q, `DSC_ZERO4, fmt_wr,
                                           fmt_ptr, fmt_echo}; // R17
                        end
                    end
                end
                default: begin
                    rsp_valid_d = 1'b0; // R22
                end
            endcase
            if (rsp_valid_d) begin
                rsp_long_d = 1'b1;
                rsp_bits_d = `DSC_LEN_LONG;
            end
        end else if (go) begin
            case (op)
                `DSC_OP_AN0: begin
                    if (hit && !glob) begin
                        rsp_valid_d = 1'b1; // R20
                        rsp_word_d  = enhanced_short_word ? {6'h00, AN0_DATA} :
                                                           {8'h00, AN0_DATA[9:2]};
                    end
                end
                `DSC_OP_AN1: begin
                    if (hit && !glob) begin
                        rsp_valid_d = 1'b1; // R20
                        rsp_word_d  = enhanced_short_word ? {6'h00, AN1_DATA} :
                                                           {8'h00, AN1_DATA[9:2]};
                    end
                end
                `DSC_OP_CLEAR: begin
                    if (hit || glob)
                        clear_d = 1'b1;
                end
                default: begin
                    rsp_valid_d = 1'b0; // R20
                end
            endcase
            if (rsp_valid_d) begin
                rsp_long_d = 1'b0;
                rsp_bits_d = sw_bits;
            end
        end
        // Clear returns every setting to its power-up value and opens both switches.
        if (clear_d) begin
            dev_addr_d             = `DSC_ADDR_RST;
            high_side_switch_ctl_d = 1'b0;
            low_side_switch_ctl_d  = 1'b0;
            oscillator_dither_d    = 1'b0; // R12
            pin_direction_d        = `DSC_ZERO3;
            pin_level_d            = `DSC_ZERO3;
            crc_poly_d             = `DSC_POLY_RST; // R21
            crc_seed_d             = `DSC_SEED_RST;
            short_word_length_d    = `DSC_SWLEN_RST; // R1
            framing_select_d       = `DSC_FSEL_STD;
        end
    end

    // The answer is sealed with the settings in force when the command arrived.
    dsc_crc4 #(
        .W     (16)
    ) u_rsp_crc (
        .data  (rsp_word_d),
        .nbits (rsp_bits_d),
        .taps  (act_poly),
        .seed  (act_seed),
        .crc   (rsp_crc_calc)
    );

    always @(posedge CLOCK) begin
        if (RST) begin
            dev_addr_q             <= `DSC_ADDR_RST;
            high_side_switch_ctl_q <= 1'b0;
            low_side_switch_ctl_q  <= 1'b0;
            oscillator_dither_q    <= 1'b0;
            pin_direction_q        <= `DSC_ZERO3;
            pin_level_q            <= `DSC_ZERO3;
            crc_poly_q             <= `DSC_POLY_RST; // R21
            crc_seed_q             <= `DSC_SEED_RST;
            short_word_length_q    <= `DSC_SWLEN_RST; // R1
            framing_select_q       <= `DSC_FSEL_STD;
            rsp_valid_q            <= 1'b0;
            rsp_long_q             <= 1'b0;
            rsp_word_q             <= 16'h0000;
            rsp_crc_q              <= `DSC_ZERO4;
            rsp_bits_q             <= 5'h00;
            crc_err_q              <= 1'b0;
        end else begin
            dev_addr_q             <= dev_addr_d;
            high_side_switch_ctl_q <= high_side_switch_ctl_d;
            low_side_switch_ctl_q  <= low_side_switch_ctl_d;
            oscillator_dither_q    <= oscillator_dither_d;
            pin_direction_q        <= pin_direction_d;
            pin_level_q            <= pin_level_d;
            crc_poly_q             <= crc_poly_d;
            crc_seed_q             <= crc_seed_d;
            short_word_length_q    <= short_word_length_d;
            framing_select_q       <= framing_select_d;
            rsp_valid_q            <= rsp_valid_d;
            rsp_long_q             <= rsp_long_d;
            rsp_word_q             <= rsp_word_d;
            rsp_bits_q             <= rsp_bits_d;
            if (rsp_valid_d)
                rsp_crc_q <= rsp_crc_calc; // R8
            crc_err_q              <= CMD_VALID && !crc_ok;
        end
    end

    assign RSP_VALID        = rsp_valid_q;
    assign RSP_LONG         = rsp_long_q;
    assign RSP_WORD         = rsp_word_q;
    assign RSP_CRC          = rsp_crc_q;
    assign RSP_BITS         = rsp_bits_q;
    assign CMD_CRC_ERR      = crc_err_q;
    assign IO_OE            = pin_direction_q; // R13
    assign IO_OUT           = pin_level_q; // R14
    assign HS_SWITCH_CLOSE  = high_side_switch_ctl_q; // R11
    assign LS_SWITCH_CLOSE  = low_side_switch_ctl_q; // R11
    assign OSC_DITHER       = oscillator_dither_q; // R12
    assign FRAMING_ENHANCED = enhanced_long_word;
    assign SHORT_WORD_BITS  = sw_bits;
endmodule // dsc_decoder

/* rtl/dsc_map.vh */
// Operation
// R1 - Short-word length holds 8 or 10, resets 8.
// R2 - Other short-word length values are discarded.
// R3 - Single write of 1111 selects programmed format.
// R4 - From 0000, imperfect 1111 write keeps standard.
// R5 - Single write of 0000 restores standard framing.
// R6 - From 1111, any 1 bit keeps programmed format.
// R7 - Programmed format locks all other format writes.
// R8 - Four-bit CRC ends every command and response.
// R9 - Long word: data, address, command code map.
// R10 - Initialization loads address, switches, dither from data.
// R11 - Switch bits close switches; status reports them.
// R12 - Dither bit selects oscillator dither, default off.
// R13 - Pin direction bits make pins outputs.
// R14 - Output pins drive the commanded level bits.
// R15 - Long response: address, four zeros, payload.
// R16 - Status reports switch states and pin levels.
// R17 - Format response echoes flag, pointer, contents.
// R18 - Format write stores data; read returns contents.
// R19 - Format acts on own or global address.
// R20 - Short words answer only converter channel requests.
// R21 - CRC taps reset to 0001, top term implied.
// R22 - Reserved codes change nothing, answer nothing.
`ifndef DSC_MAP_VH
`define DSC_MAP_VH

// Command word fields.
`define DSC_F_OP        3:0
`define DSC_F_ADDR      7:4
`define DSC_F_DATA      15:8
`define DSC_F_SWDATA    9:8
`define DSC_B_HS        14
`define DSC_B_LS        13
`define DSC_B_DITHER    12
`define DSC_F_NEWADDR   11:8
`define DSC_F_LEVEL     14:12
`define DSC_F_DIR       10:8
`define DSC_B_RW        15
`define DSC_F_PTR       14:12
`define DSC_F_VAL       11:8

// Command codes.
`define DSC_OP_INIT     4'h0
`define DSC_OP_STATUS   4'h1
`define DSC_OP_AN0      4'h2
`define DSC_OP_IOCTL    4'h3
`define DSC_OP_ID       4'h4
`define DSC_OP_AN1      4'h5
`define DSC_OP_CLEAR    4'h7
`define DSC_OP_FMT      4'ha

// Format control locations.
`define DSC_LOC_POLY    3'h0
`define DSC_LOC_SEED    3'h2
`define DSC_LOC_SWLEN   3'h5
`define DSC_LOC_FSEL    3'h7

// Reset and coded values.
`define DSC_POLY_RST    4'h1
`define DSC_SEED_RST    4'ha
`define DSC_SWLEN_RST   4'h8
`define DSC_SWLEN_ALT   4'ha
`define DSC_FSEL_STD    4'h0
`define DSC_FSEL_ENH    4'hf
`define DSC_ADDR_RST    4'h0
`define DSC_ADDR_GLOBAL 4'h0
`define DSC_ZERO4       4'h0
`define DSC_ZERO3       3'h0
`define DSC_ZERO2       2'h0
`define DSC_ZERO1       1'h0

// Word lengths in bits, CRC excluded.
`define DSC_LEN_LONG    5'h10
`define DSC_LEN_SW8     5'h08
`define DSC_LEN_SW10    5'h0a

`endif

/* rtl/dsc_crc4.v */
`timescale 1ns/1ps
module dsc_crc4 #(
    parameter W = 16
) (
    input  wire [W-1:0] data,
    input  wire [4:0]   nbits,
    input  wire [3:0]   taps,
    input  wire [3:0]   seed,
    output reg  [3:0]   crc
);
    reg     [3:0] c;
    reg           fb;
    integer       i;

    // Bits are shifted in most significant first; only the low nbits take part.
    always @* begin
        c  = seed;
        fb = 1'b0;
        for (i = W - 1; i >= 0; i = i - 1) begin
            if (i < nbits) begin
                fb = c[3] ^ data[i];
                c  = {c[2:0], 1'b0} ^ ({4{fb}} & taps); // R21
            end
        end
        crc = c;
    end
endmodule // dsc_crc4

/* test/dsc_decoder_monitor.sv */
`timescale 1ns/1ps
module dsc_decoder_monitor (
    input logic        CLOCK,
    input logic        RST,
    input logic        CMD_VALID,
    input logic        CMD_LONG,
    input logic [15:0] CMD_WORD,
    input logic [2:0]  IO_IN,
    input logic        RSP_VALID,
    input logic        RSP_LONG,
    input logic [15:0] RSP_WORD,
    input logic [4:0]  RSP_BITS,
    input logic        CMD_CRC_ERR,
    input logic [2:0]  IO_OE,
    input logic        HS_SWITCH_CLOSE,
    input logic        LS_SWITCH_CLOSE,
    input logic        FRAMING_ENHANCED,
    input logic [4:0]  SHORT_WORD_BITS
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    a_rsp_needs_cmd: assert property (RSP_VALID |-> $past(CMD_VALID))
        else $error("Response without a command.");
    a_long_rsp_layout: assert property (RSP_VALID && RSP_LONG |->
        RSP_WORD[11:8] == 4'h0 && RSP_BITS == 5'h10)
        else $error("Long response layout wrong.");
    a_short_rsp_codes: assert property (RSP_VALID && !RSP_LONG |->
        $past(!CMD_LONG && (CMD_WORD[3:0] == 4'h2 || CMD_WORD[3:0] == 4'h5)))
        else $error("Short response to a wrong code.");
    a_status_fields: assert property (RSP_VALID && RSP_LONG && $past(CMD_WORD[3:0]) == 4'h1
        |-> RSP_WORD[6:5] == {HS_SWITCH_CLOSE, LS_SWITCH_CLOSE}
        && RSP_WORD[2:0] == $past(IO_IN))
        else $error("Status fields wrong.");
    a_crc_err_silent: assert property (CMD_CRC_ERR |-> !RSP_VALID)
        else $error("Answer to a corrupted command.");
    a_reserved_inert: assert property (CMD_VALID && CMD_WORD[3:0] inside
        {4'h6, 4'h8, 4'h9, [4'hb:4'hf]} |=> !RSP_VALID && $stable(IO_OE)
        && $stable(FRAMING_ENHANCED) && $stable(SHORT_WORD_BITS))
        else $error("Reserved code had an effect.");
    a_enh_needs_ones: assert property ($rose(FRAMING_ENHANCED) |-> $past(CMD_VALID && CMD_LONG
        && CMD_WORD[15:8] == 8'hff && CMD_WORD[3:0] == 4'ha))
        else $error("Enhanced framing without a full write.");
    a_std_needs_zeros: assert property ($fell(FRAMING_ENHANCED) |-> $past(RST)
        || $past(CMD_VALID && (CMD_WORD[3:0] == 4'h7
        || (CMD_WORD[3:0] == 4'ha && CMD_WORD[15:8] == 8'hf0))))
        else $error("Standard framing without a zero write.");
    a_pins_by_cmd: assert property (!$stable(IO_OE) |-> $past(RST)
        || $past(CMD_VALID && (CMD_WORD[3:0] == 4'h3 || CMD_WORD[3:0] == 4'h7)))
        else $error("Pin direction changed without a command.");
    a_switch_by_cmd: assert property (!$stable({HS_SWITCH_CLOSE, LS_SWITCH_CLOSE}) |-> $past(RST)
        || $past(CMD_VALID && (CMD_WORD[3:0] == 4'h0 || CMD_WORD[3:0] == 4'h7)))
        else $error("Switch changed without a command.");
    a_swlen_legal: assert property (SHORT_WORD_BITS == 5'h08
        || (SHORT_WORD_BITS == 5'h0a && FRAMING_ENHANCED))
        else $error("Short-word length illegal.");

    c_enhanced: cover property ($rose(FRAMING_ENHANCED));
    c_short_rsp: cover property (RSP_VALID && !RSP_LONG);
    c_crc_err: cover property (CMD_CRC_ERR);
endmodule // dsc_decoder_monitor

bind dsc_decoder dsc_decoder_monitor dsc_decoder_monitor_i (
    .CLOCK(CLOCK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD_LONG(CMD_LONG),
    .CMD_WORD(CMD_WORD), .IO_IN(IO_IN), .RSP_VALID(RSP_VALID), .RSP_LONG(RSP_LONG),
    .RSP_WORD(RSP_WORD), .RSP_BITS(RSP_BITS), .CMD_CRC_ERR(CMD_CRC_ERR), .IO_OE(IO_OE),
    .HS_SWITCH_CLOSE(HS_SWITCH_CLOSE), .LS_SWITCH_CLOSE(LS_SWITCH_CLOSE),
    .FRAMING_ENHANCED(FRAMING_ENHANCED), .SHORT_WORD_BITS(SHORT_WORD_BITS));

/* test/dsc_master.sv */
`timescale 1ns/1ps
module dsc_master #(
    parameter logic [3:0] TAPS = 4'h1,
    parameter logic [3:0] SEED = 4'ha
) (
    input  logic        CLOCK,
    output logic        CMD_VALID,
    output logic        CMD_LONG,
    output logic [15:0] CMD_WORD,
    output logic [3:0]  CMD_CRC
);
    initial begin
        CMD_VALID = 1'b0;
        CMD_LONG = 1'b0;
        CMD_WORD = 16'h0000;
        CMD_CRC = 4'h0;
    end

    function automatic logic [3:0] crc4(input logic [15:0] d, input logic [4:0] n);
        logic [3:0] c;
        c = SEED;
        for (int i = 15; i >= 0; i--) begin
            if (i < n) begin
                c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? TAPS : 4'h0);
            end
        end
        return c;
    endfunction

    // Released lines show the inverse so a stale word is never taken for a fresh one.
    task automatic send(input logic lng, input logic [15:0] w, input logic [4:0] n,
                        input logic bad);
        @(negedge CLOCK);
        CMD_VALID = 1'b1;
        CMD_LONG = lng;
        CMD_WORD = w;
        CMD_CRC = crc4(w, n) ^ {3'h0, bad};
        @(negedge CLOCK);
        CMD_VALID = 1'b0;
        CMD_LONG = ~lng;
        CMD_WORD = ~w;
        CMD_CRC = ~CMD_CRC;
    endtask
endmodule // dsc_master

/* test/dsc_slave_command_decoder_tb.sv */
`timescale 1ns/1ps
module dsc_slave_command_decoder_tb;
    logic        CLOCK, RST, CMD_VALID, CMD_LONG, FUSE_PARITY_FLAG;
    logic [15:0] CMD_WORD, RSP_WORD;
    logic [3:0]  CMD_CRC, RSP_CRC;
    logic [9:0]  AN0_DATA, AN1_DATA;
    logic [2:0]  IO_IN, IO_OUT, IO_OE;
    logic        RSP_VALID, RSP_LONG, CMD_CRC_ERR, OSC_DITHER;
    logic        HS_SWITCH_CLOSE, LS_SWITCH_CLOSE, FRAMING_ENHANCED;
    logic [4:0]  RSP_BITS, SHORT_WORD_BITS;
    int          error_cnt = 0;
    int          n_checks = 0;
    int          cycles = 0;
    localparam logic [3:0] VER = 4'h9; // Arbitrary value.

    dsc_decoder #(.VERSION(VER)) dsc_decoder_i (
        .CLOCK(CLOCK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD_LONG(CMD_LONG),
        .CMD_WORD(CMD_WORD), .CMD_CRC(CMD_CRC), .AN0_DATA(AN0_DATA), .AN1_DATA(AN1_DATA),
        .IO_IN(IO_IN), .FUSE_PARITY_FLAG(FUSE_PARITY_FLAG), .RSP_VALID(RSP_VALID),
        .RSP_LONG(RSP_LONG), .RSP_WORD(RSP_WORD), .RSP_CRC(RSP_CRC), .RSP_BITS(RSP_BITS),
        .CMD_CRC_ERR(CMD_CRC_ERR), .IO_OUT(IO_OUT), .IO_OE(IO_OE),
        .HS_SWITCH_CLOSE(HS_SWITCH_CLOSE), .LS_SWITCH_CLOSE(LS_SWITCH_CLOSE),
        .OSC_DITHER(OSC_DITHER), .FRAMING_ENHANCED(FRAMING_ENHANCED),
        .SHORT_WORD_BITS(SHORT_WORD_BITS));
    dsc_master dsc_master_i (
        .CLOCK(CLOCK), .CMD_VALID(CMD_VALID), .CMD_LONG(CMD_LONG),
        .CMD_WORD(CMD_WORD), .CMD_CRC(CMD_CRC));

    initial begin
        CLOCK = 1'b0;
        forever #25 CLOCK = ~CLOCK;
    end

    task end_sim;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            end_sim;
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rsp(input logic [15:0] w, input logic [4:0] nb);
        chk(RSP_VALID, 1'b1);
        chk(RSP_WORD, w);
        chk(RSP_BITS, nb);
        chk(RSP_LONG, nb == 5'h10);
        chk(RSP_CRC, dsc_master_i.crc4(w, nb));
    endtask

    task automatic lw(input logic [15:0] w);
        dsc_master_i.send(1'b1, w, 5'h10, 1'b0);
    endtask

    // Format command to the initialized address 5, echo checked.
    task automatic fw(input logic [7:0] d, input logic [7:0] e);
        lw({d, 8'h5a});
        rsp({8'h50, e}, 5'h10);
    endtask

    task t_reset;
        chk(SHORT_WORD_BITS, 5'h08);
        chk(FRAMING_ENHANCED, 1'b0);
        chk({HS_SWITCH_CLOSE, LS_SWITCH_CLOSE, OSC_DITHER}, 3'b000);
    endtask

    task t_init_status;
        lw(16'h7500);
        rsp(16'h5065, 5'h10);
        chk({HS_SWITCH_CLOSE, LS_SWITCH_CLOSE, OSC_DITHER}, 3'b111);
        lw(16'h0051);
        rsp(16'h5062, 5'h10);
        dsc_master_i.send(1'b1, 16'h0051, 5'h10, 1'b1);
        chk({RSP_VALID, CMD_CRC_ERR}, 2'b01);
        lw(16'h0091);
        chk(RSP_VALID, 1'b0);
    endtask

    task t_pins;
        lw(16'h5353);
        rsp(16'h5053, 5'h10);
        chk(IO_OE, 3'b011);
        chk(IO_OUT, 3'b101);
        lw(16'h0055);
        rsp(16'h50f1, 5'h10);
    endtask

    task t_reserved;
        for (int k = 6; k < 16; k++) begin
            if (k != 7 && k != 10) begin
                lw({12'hff5, k[3:0]});
                chk(RSP_VALID, 1'b0);
                chk(IO_OE, 3'b011);
            end
        end
    endtask

    // The identification reply carries the version and the live fuse parity flag.
    task t_id;
        FUSE_PARITY_FLAG = 1'b1;
        lw(16'h0054);
        rsp({8'h50, VER, 4'h1}, 5'h10);
        FUSE_PARITY_FLAG = 1'b0;
        lw(16'h0054);
        rsp({8'h50, VER, 4'h0}, 5'h10);
    endtask

    task t_format;
        lw(16'hda0a);
        chk(RSP_VALID, 1'b0);
        fw(8'h50, 8'h5a);
        fw(8'hd9, 8'hda);
        fw(8'h00, 8'h01);
        fw(8'hfe, 8'hf0);
        chk(FRAMING_ENHANCED, 1'b0);
        fw(8'hff, 8'hff);
        chk({FRAMING_ENHANCED, SHORT_WORD_BITS}, 6'h2a);
        fw(8'hd8, 8'hda);
        chk(SHORT_WORD_BITS, 5'h0a);
        dsc_master_i.send(1'b0, 16'h0052, 5'h0a, 1'b0);
        rsp(16'h02a5, 5'h0a);
        dsc_master_i.send(1'b0, 16'h0051, 5'h0a, 1'b0);
        chk(RSP_VALID, 1'b0);
        fw(8'hf1, 8'hff);
        chk(FRAMING_ENHANCED, 1'b1);
        fw(8'hf0, 8'hf0);
        chk({FRAMING_ENHANCED, SHORT_WORD_BITS}, 6'h08);
        dsc_master_i.send(1'b0, 16'h0055, 5'h08, 1'b0);
        rsp(16'h00f1, 5'h08);
    endtask

    task t_clear;
        lw(16'h0057);
        chk(RSP_VALID, 1'b0);
        chk({HS_SWITCH_CLOSE, LS_SWITCH_CLOSE, OSC_DITHER, IO_OE}, 6'h00);
        lw(16'h0300);
        rsp(16'h3003, 5'h10);
    endtask

    initial begin
        RST = 1'b1;
        AN0_DATA = 10'h2a5;
        AN1_DATA = 10'h3c4;
        IO_IN = 3'b010;
        FUSE_PARITY_FLAG = 1'b0;
        repeat (4) @(posedge CLOCK);
        @(negedge CLOCK);
        RST = 1'b0;
        t_reset;
        t_init_status;
        t_pins;
        t_reserved;
        t_id;
        t_format;
        t_clear;
        end_sim;
    end
endmodule // dsc_slave_command_decoder_tb
